// File: sim/fwhc_link_host_control_assertions.sv
// Port-level checks for the host control register block.
`include "fwhc_params.svh"
`default_nettype none
module fwhc_link_host_control_assertions #(
  parameter logic [31:0] VENDOR_CODE = 32'h0000_0a5c
) (
  input wire logic                 clk,             // Clock.
  input wire logic                 rstn,            // Reset, low.
  input wire fwhc_pkg::fwhc_addr_t regAddr,         // Offset.
  input wire logic                 regWr,           // Write.
  input wire logic                 regRd,           // Read.
  input wire fwhc_pkg::fwhc_word_t regRdata,        // Read data.
  input wire logic                 regRdValid,      // Data valid.
  input wire logic                 regAbort,        // Abort.
  input wire logic                 suppressTargetAbort, // All ones.
  input wire logic                 phyClockRunning, // PHY clock.
  input wire logic                 romReadReq,      // ROM read.
  input wire logic                 romReadGrant,    // Answered.
  input wire logic                 romReadTypeErr,  // Type error.
  input wire logic                 busReset,        // Bus reset.
  input wire logic                 romRegsUpdate,   // ROM reload.
  input wire logic                 tardyWanted,     // Late need.
  input wire logic                 sendAckTardy,    // Late ack.
  input wire logic                 lateAckEvent,    // Event bit.
  input wire logic                 linkPowerStatus, // Power flag.
  input wire logic                 linkConnected,   // Connected.
  input wire logic                 restartFlush     // Restarting.
);
  import fwhc_pkg::*;
  logic [2:0] runHist;
  // The history starts high so the synchroniser's reset value is not judged.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) runHist <= 3'h7;
    else runHist <= {runHist[1:0], phyClockRunning};
  end
  wire logic stopped = !phyClockRunning && runHist == 3'h0;
  wire logic inPhy = (regAddr >= 12'h0dc && regAddr <= 12'h0f0) ||
                     (regAddr >= 12'h100 && regAddr <= 12'h11c);
  wire logic hcAddr = regAddr == 12'h050 || regAddr == 12'h054;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rd_answer_a: assert property (regRd |=> regRdValid != regAbort)
    else $error("read not answered once");
  vendor_fixed_a: assert property (regRd && regAddr == 12'h040 |=>
    regRdValid && regRdata == VENDOR_CODE) else $error("vendor code");
  reserved_zero_a: assert property (regRd && hcAddr |=>
    (regRdata & 32'h1f30_ffff) == 32'h0) else $error("reserved bits set");
  abort_stopped_a: assert property (regRd && inPhy && stopped &&
    !suppressTargetAbort |=> regAbort) else $error("no abort");
  all_ones_a: assert property (regRd && inPhy && stopped &&
    suppressTargetAbort |=> regRdValid && regRdata == `FWHC_ALL_ONES)
    else $error("no all ones");
  rom_answer_a: assert property (romReadReq && linkConnected |=>
    romReadGrant != romReadTypeErr) else $error("rom read answer");
  link_gate_a: assert property (!linkConnected |=> !sendAckTardy &&
    !romReadGrant && !romRegsUpdate) else $error("traffic while off");
  tardy_event_a: assert property (sendAckTardy |-> lateAckEvent &&
    $past(tardyWanted)) else $error("late ack without event");
  restart_len_a: assert property ($rose(restartFlush) |->
    restartFlush [*8] ##1 !restartFlush) else $error("restart length");
  power_cause_a: assert property ($changed(linkPowerStatus) |->
    $past(regWr) || restartFlush || $past(restartFlush))
    else $error("power flag moved alone");
  bus_update_a: assert property (romRegsUpdate |-> $past(busReset))
    else $error("rom reload without bus reset");
endmodule
bind fwhc_link_host_control fwhc_link_host_control_assertions #(
  .VENDOR_CODE(VENDOR_CODE)) chk (.clk, .rstn, .regAddr, .regWr, .regRd,
  .regRdata, .regRdValid, .regAbort, .suppressTargetAbort, .phyClockRunning,
  .romReadReq, .romReadGrant, .romReadTypeErr, .busReset, .romRegsUpdate,
  .tardyWanted, .sendAckTardy, .lateAckEvent, .linkPowerStatus,
  .linkConnected, .restartFlush);
`default_nettype wire

// File: sim/fwhc_remote_node.sv
// Remote serial bus node that raises link events toward the block.
`default_nettype none
module fwhc_remote_node (
  input  wire logic        clk,          // Clock.
  output var  logic        romReadReq,   // ROM block read.
  output var  logic        tardyWanted,  // Access needing a late ack.
  output var  logic        busReset,     // Serial bus reset.
  output var  logic        pwFail,       // Posted write failed.
  output var  logic [15:0] pwRequester,  // Bus and node number.
  output var  logic [15:0] pwOffsetUpper // Upper offset bits.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {pwFail, busReset, tardyWanted, romReadReq} = 4'h0;
    pwRequester = 16'h5a5a;
    pwOffsetUpper = 16'ha5a5;
  end
  // One event for one cycle; afterwards the identity lines flip so a
  // capture taken late cannot match by accident.
  task automatic ev(input int k, input logic [15:0] id = 16'h0,
                    input logic [15:0] off = 16'h0);
    @(posedge clk);
    {pwFail, busReset, tardyWanted, romReadReq} <= 4'h1 << k;
    pwRequester <= id;
    pwOffsetUpper <= off;
    @(posedge clk);
    {pwFail, busReset, tardyWanted, romReadReq} <= 4'h0;
    pwRequester <= ~id;
    pwOffsetUpper <= ~off;
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the host control register block.
`include "fwhc_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fwhc_pkg::*;
  localparam fwhc_word_t VID = 32'h0000_0a5c; // Arbitrary value.
  logic clk = 0, rstn = 0, regWr = 0, regRd = 0, ownerLoad = 0;
  logic suppressTargetAbort = 0, phyClockRunning = 0, ownerValue = 1;
  logic romFetchError = 0, regRdValid, regAbort, romReadGrant;
  logic romReadTypeErr, romRegsUpdate, sendAckTardy, lateAckEvent;
  logic skipByteSwap, phyEnhancementOn, linkPowerStatus, postedWriteOn;
  logic linkConnected, restartFlush, romReadReq, busReset, tardyWanted;
  logic pwFail;
  logic [15:0] pwRequester, pwOffsetUpper;
  fwhc_addr_t regAddr = '0;
  fwhc_word_t regWdata = '0, regRdata;
  int n_errors = 0, num_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  fwhc_link_host_control #(.VENDOR_CODE(VID)) dut (.clk, .rstn, .regAddr,
    .regWr, .regRd, .regWdata, .regRdata, .regRdValid, .regAbort,
    .suppressTargetAbort, .phyClockRunning, .ownerLoad, .ownerValue, .pwFail,
    .pwRequester, .pwOffsetUpper, .romFetchError, .romReadReq, .romReadGrant,
    .romReadTypeErr, .busReset, .romRegsUpdate, .tardyWanted, .sendAckTardy,
    .lateAckEvent, .skipByteSwap, .phyEnhancementOn, .linkPowerStatus,
    .postedWriteOn, .linkConnected, .restartFlush);
  fwhc_remote_node node (.clk, .romReadReq, .tardyWanted, .busReset,
    .pwFail, .pwRequester, .pwOffsetUpper);
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input fwhc_word_t exp, got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input fwhc_addr_t a, input fwhc_word_t d);
    @(posedge clk);
    regWr <= 1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 0;
  endtask
  // Waits a bounded time for the answer, then compares the masked data.
  task automatic rd(input fwhc_addr_t a, input fwhc_word_t e,
                    input logic ab = 0, input fwhc_word_t m = '1);
    int i;
    @(posedge clk);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 0;
    #1;
    for (i = 0; i < 3 && regRdValid !== 1 && regAbort !== 1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("abort", {31'h0, ab}, {31'h0, regAbort});
    if (!ab) chk("read data", e & m, regRdata & m);
  endtask
  // Pulse one event from the far node and look at the answer after it.
  task automatic ev(input int k, input logic [15:0] id = 16'h0,
                    input logic [15:0] off = 16'h0);
    node.ev(k, id, off);
    #1;
  endtask
  task automatic t_basic();
    rd(`FWHC_OFF_HC_SET, 32'h0080_0000);
    rd(`FWHC_OFF_HC_CLEAR, 32'h0080_0000);
    wr(`FWHC_OFF_VENDOR, 32'hffff_ffff);
    rd(`FWHC_OFF_VENDOR, VID);
    rd(12'h0dc, 32'h0, 1);
    @(posedge clk) suppressTargetAbort <= 1;
    rd(12'h11c, 32'hffff_ffff);
    @(posedge clk) suppressTargetAbort <= 0;
    phyClockRunning <= 1;
    repeat (3) @(posedge clk);
    rd(12'h0f0, 32'h0);
  endtask
  task automatic t_flags();
    wr(`FWHC_OFF_HC_SET, 32'hffe6_ffff); // node is not bus manager
    rd(`FWHC_OFF_HC_CLEAR, 32'he086_0000);
    chk("swap", 1, skipByteSwap);
    chk("posted", 1, postedWriteOn);
    wr(`FWHC_OFF_HC_SET, 32'h0040_0000);
    wr(`FWHC_OFF_HC_CLEAR, 32'h8000_0000);
    rd(`FWHC_OFF_HC_SET, 32'he0c6_0000);
    chk("enhancement", 1, phyEnhancementOn);
    chk("connected", 1, linkConnected);
    ev(2);
    chk("rom reload", 1, romRegsUpdate);
    ev(0);
    chk("rom grant", 1, romReadGrant);
    ev(1);
    chk("late ack", 3, {sendAckTardy, lateAckEvent});
    ev(3, 16'habcd, 16'h1234);
    rd(`FWHC_OFF_PW_FAIL_HIGH, 32'habcd_1234);
  endtask
  task automatic t_fetch();
    @(posedge clk) romFetchError <= 1;
    @(posedge clk) romFetchError <= 0;
    rd(`FWHC_OFF_HC_CLEAR, 32'h60c6_0000);
    ev(0);
    chk("type error", 1, romReadTypeErr);
    ev(2);
    chk("rom reload", 0, romRegsUpdate);
    wr(`FWHC_OFF_HC_SET, 32'h8000_0000);
    wr(`FWHC_OFF_HC_CLEAR, 32'h0004_0000);
    wr(`FWHC_OFF_HC_SET, 32'h0);
    rd(`FWHC_OFF_HC_SET, 32'h60c6_0000);
    wr(`FWHC_OFF_HC_CLEAR, 32'h0002_0000);
    ev(1);
    chk("late ack off", 0, sendAckTardy);
    chk("connected", 0, linkConnected);
    wr(`FWHC_OFF_HC_CLEAR, 32'h6044_0000);
    rd(`FWHC_OFF_HC_SET, 32'h0080_0000);
  endtask
  task automatic t_restart();
    @(posedge clk) ownerLoad <= 1;
    ownerValue <= 0;
    @(posedge clk) ownerLoad <= 0;
    wr(`FWHC_OFF_HC_SET, 32'h2001_0000);
    rd(`FWHC_OFF_HC_CLEAR, 32'h0001_0000, 0, 32'h0001_0000);
    chk("flush", 1, restartFlush);
    repeat (10) @(posedge clk);
    rd(`FWHC_OFF_HC_CLEAR, 32'h0);
    rd(`FWHC_OFF_PW_FAIL_HIGH, 32'h0);
    wr(`FWHC_OFF_HC_SET, 32'h0008_0000);
    // Let the flop settle past the edge that takes the write.
    #1;
    chk("power", 1, linkPowerStatus);
    // No register traffic while the PHY clock settles.
    repeat (20) @(posedge clk);
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    rd(`FWHC_OFF_HC_SET, 32'h0080_0000);
  endtask
  // A hang is cut after far more cycles than the sequence needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    t_basic();
    t_flags();
    t_fetch();
    t_restart();
    give_verdict();
  end
endmodule
`default_nettype wire

// File: verilog/fwhc_flag_cell.sv
// One set/clear control flag with a forced return to its reset value.
`default_nettype none
module fwhc_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,      // Block clock.
  input  wire logic rstn,     // Asynchronous reset, active low.
  input  wire logic forceRst, // Return to reset value, highest priority.
  input  wire logic setReq,   // Set request.
  input  wire logic clrReq,   // Clear request.
  output var  logic flag      // Current flag value.
);
  // A set in the same cycle as a clear wins, so no set is lost.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag <= RESET_VAL;
    end else if (forceRst) begin
      flag <= RESET_VAL;
    end else if (setReq) begin
      flag <= 1'b1;
    end else if (clrReq) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verilog/fwhc_link_host_control.sv
// Host control, vendor identity and posted-write failure capture registers.
`include "fwhc_params.svh"
`default_nettype none
module fwhc_link_host_control #(
  // Arbitrary neutral identity value.
  parameter logic [31:0] VENDOR_CODE = 32'h0000_0a5c
) (
  input  wire logic               clk,            // Bus-side clock, 10 MHz.
  input  wire logic               rstn,           // Hardware reset, low.
  input  wire fwhc_pkg::fwhc_addr_t regAddr,      // Register byte offset.
  input  wire logic               regWr,          // Write strobe.
  input  wire logic               regRd,          // Read strobe.
  input  wire fwhc_pkg::fwhc_word_t regWdata,     // Write data.
  output var  fwhc_pkg::fwhc_word_t regRdata,     // Read data.
  output var  logic               regRdValid,     // Read data valid pulse.
  output var  logic               regAbort,       // Target abort pulse.
  input  wire logic               suppressTargetAbort, // Config bit.
  input  wire logic               phyClockRunning,// PHY clock alive, async.
  input  wire logic               ownerLoad,      // Serial memory load pulse.
  input  wire logic               ownerValue,     // Loaded owner value.
  input  wire logic               pwFail,         // Posted write failed.
  input  wire logic [15:0]        pwRequester,    // Bus and node number.
  input  wire logic [15:0]        pwOffsetUpper,  // Offset bits 47:32.
  input  wire logic               romFetchError,  // Info block fetch failed.
  input  wire logic               romReadReq,     // ROM block read arrives.
  output var  logic               romReadGrant,   // Answer the read.
  output var  logic               romReadTypeErr, // Answer ack_type_error.
  input  wire logic               busReset,       // Serial bus reset pulse.
  output var  logic               romRegsUpdate,  // Reload ROM-image regs.
  input  wire logic               tardyWanted,    // Link cannot answer now.
  output var  logic               sendAckTardy,   // Send ack_tardy pulse.
  output var  logic               lateAckEvent,   // Sets event bit 27.
  output var  logic               skipByteSwap,   // No DMA byte swap.
  output var  logic               phyEnhancementOn, // Enhancements on.
  output var  logic               linkPowerStatus,  // Link-PHY talk allowed.
  output var  logic               postedWriteOn,    // Posted writes enabled.
  output var  logic               linkConnected,    // Packets may flow.
  output var  logic               restartFlush      // Flush link state.
);
  import fwhc_pkg::*;

  fwhc_restart_t restartState;
  logic [3:0]    restartCount;
  fwhc_word_t    pwFailHigh;
  logic          imageOk;
  logic          latePermit;
  logic          phyOwner;
  logic          linkActive;
  logic          phyClkOk;
  logic          restarting;
  logic          wrSet;
  logic          wrClr;
  fwhc_word_t    setBits;
  fwhc_word_t    clrBits;
  fwhc_word_t    hcValue;
  logic          phyAddr;

  assign restarting = (restartState == FWHC_RS_FLUSH);

  // Ones act at the set or clear address; zeros leave flags alone.
  assign wrSet   = regWr && (regAddr == `FWHC_OFF_HC_SET);
  assign wrClr   = regWr && (regAddr == `FWHC_OFF_HC_CLEAR);
  assign setBits = wrSet ? regWdata : '0;
  assign clrBits = wrClr ? regWdata : '0;

  // PHY clock state comes from the other domain, so it is synchronised.
  fwhc_sync u_phy_clk_sync (
    .clk    (clk),
    .rstn   (rstn),
    .async  (phyClockRunning),
    .synced (phyClkOk)
  );

  // Image-ok is only set while the link is off; fetch error also clears it.
  fwhc_flag_cell #(.RESET_VAL(`FWHC_RST_IMAGE_OK)) u_image_ok (
    .clk      (clk),
    .rstn     (rstn),
    .forceRst (restarting || romFetchError),
    .setReq   (setBits[`FWHC_BIT_IMAGE_OK] && !linkActive),
    // Software cannot clear it; only the resets and a fetch error do.
    .clrReq   (1'b0),
    .flag     (imageOk)
  );

  fwhc_flag_cell #(.RESET_VAL(`FWHC_RST_SKIP_SWAP)) u_skip_swap (
    .clk      (clk),
    .rstn     (rstn),
    .forceRst (restarting),
    .setReq   (setBits[`FWHC_BIT_SKIP_SWAP]),
    .clrReq   (clrBits[`FWHC_BIT_SKIP_SWAP]),
    .flag     (skipByteSwap)
  );

  fwhc_flag_cell #(.RESET_VAL(`FWHC_RST_LATE_ACK)) u_late_ack (
    .clk      (clk),
    .rstn     (rstn),
    .forceRst (restarting),
    .setReq   (setBits[`FWHC_BIT_LATE_ACK]),
    .clrReq   (clrBits[`FWHC_BIT_LATE_ACK]),
    .flag     (latePermit)
  );

  // Enhancements may only be turned on by their owner on a live link.
  fwhc_flag_cell #(.RESET_VAL(`FWHC_RST_PHY_ENH)) u_phy_enh (
    .clk      (clk),
    .rstn     (rstn),
    .forceRst (restarting),
    .setReq   (setBits[`FWHC_BIT_PHY_ENH] && phyOwner && linkActive),
    .clrReq   (clrBits[`FWHC_BIT_PHY_ENH] && phyOwner),
    .flag     (phyEnhancementOn)
  );

  fwhc_flag_cell #(.RESET_VAL(`FWHC_RST_LINK_POWER)) u_link_power (
    .clk      (clk),
    .rstn     (rstn),
    .forceRst (restarting),
    .setReq   (setBits[`FWHC_BIT_LINK_POWER]),
    .clrReq   (clrBits[`FWHC_BIT_LINK_POWER]),
    .flag     (linkPowerStatus)
  );

  // Changes while the link runs are ignored, so traffic never sees a flip.
  fwhc_flag_cell #(.RESET_VAL(`FWHC_RST_POSTED_WR)) u_posted_wr (
    .clk      (clk),
    .rstn     (rstn),
    .forceRst (restarting),
    .setReq   (setBits[`FWHC_BIT_POSTED_WR] && !linkActive),
    .clrReq   (clrBits[`FWHC_BIT_POSTED_WR] && !linkActive),
    .flag     (postedWriteOn)
  );

  fwhc_flag_cell #(.RESET_VAL(`FWHC_RST_LINK_ACTIVE)) u_link_active (
    .clk      (clk),
    .rstn     (rstn),
    .forceRst (restarting),
    .setReq   (setBits[`FWHC_BIT_LINK_ACTIVE]),
    .clrReq   (clrBits[`FWHC_BIT_LINK_ACTIVE]),
    .flag     (linkActive)
  );

  // Owner flag survives a software restart; only the hard reset and an ownerLoad pulse change it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phyOwner <= `FWHC_RST_PHY_OWNER;
    end else if (ownerLoad) begin
      phyOwner <= ownerValue;
    end
  end

  // Restart runs a fixed flush; bit 16 reads one for its whole length.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      restartState <= FWHC_RS_IDLE;
      restartCount <= 4'h0;
    end else begin
      unique case (restartState)
        FWHC_RS_IDLE: begin
          if (setBits[`FWHC_BIT_SW_RESTART]) begin
            restartState <= FWHC_RS_FLUSH;
            restartCount <= `FWHC_RESTART_CYCLES;
          end
        end
        FWHC_RS_FLUSH: begin
          if (restartCount == 4'h1) begin
            restartState <= FWHC_RS_IDLE;
          end
          restartCount <= restartCount - 4'h1;
        end
      endcase
    end
  end

  // Flush strobe for FIFOs and link state elsewhere in the controller.
  assign restartFlush = restarting;

  // The link is cut the moment link-active drops or a restart runs.
  assign linkConnected = linkActive && !restarting;

  // Capture the identity and upper offset of a failed posted write.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwFailHigh <= `FWHC_RST_CAPTURE;
    end else if (restarting) begin
      pwFailHigh <= `FWHC_RST_CAPTURE;
    end else if (pwFail) begin
      pwFailHigh <= {pwRequester, pwOffsetUpper};
    end
  end

  // ROM block reads are answered only on a connected link.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      romReadGrant   <= 1'b0;
      romReadTypeErr <= 1'b0;
    end else begin
      romReadGrant   <= romReadReq && linkConnected && imageOk;
      romReadTypeErr <= romReadReq && linkConnected && !imageOk;
    end
  end

  // Without a valid image the ROM-related registers keep their old values.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      romRegsUpdate <= 1'b0;
    end else begin
      romRegsUpdate <= busReset && imageOk && linkConnected;
    end
  end

  // Every tardy ack raises the late-acknowledge event in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sendAckTardy <= 1'b0;
      lateAckEvent <= 1'b0;
    end else begin
      sendAckTardy <= tardyWanted && latePermit && linkConnected;
      lateAckEvent <= tardyWanted && latePermit && linkConnected;
    end
  end

  // Reserved positions are tied low in the read image.
  always_comb begin
    hcValue = '0;
    hcValue[`FWHC_BIT_IMAGE_OK]    = imageOk;
    hcValue[`FWHC_BIT_SKIP_SWAP]   = skipByteSwap;
    hcValue[`FWHC_BIT_LATE_ACK]    = latePermit;
    hcValue[`FWHC_BIT_PHY_OWNER]   = phyOwner;
    hcValue[`FWHC_BIT_PHY_ENH]     = phyEnhancementOn;
    hcValue[`FWHC_BIT_LINK_POWER]  = linkPowerStatus;
    hcValue[`FWHC_BIT_POSTED_WR]   = postedWriteOn;
    hcValue[`FWHC_BIT_LINK_ACTIVE] = linkActive;
    hcValue[`FWHC_BIT_SW_RESTART]  = restarting;
  end

  assign phyAddr =
    ((regAddr >= `FWHC_PHY_LO_FIRST) && (regAddr <= `FWHC_PHY_LO_LAST)) ||
    ((regAddr >= `FWHC_PHY_HI_FIRST) && (regAddr <= `FWHC_PHY_HI_LAST));

  // Read data is registered; a stopped PHY clock turns PHY-range access into abort, or into all ones if suppressed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata   <= '0;
      regRdValid <= 1'b0;
      regAbort   <= 1'b0;
    end else begin
      regRdValid <= 1'b0;
      regAbort   <= 1'b0;
      if ((regRd || regWr) && phyAddr && !phyClkOk) begin
        // Aborts can hang a host, so software may ask for ones instead.
        regAbort   <= !suppressTargetAbort;
        regRdValid <= regRd && suppressTargetAbort;
        regRdata   <= `FWHC_ALL_ONES;
      end else if (regRd) begin
        regRdValid <= 1'b1;
        unique case (regAddr)
          `FWHC_OFF_PW_FAIL_HIGH: regRdata <= pwFailHigh;
          `FWHC_OFF_VENDOR:       regRdata <= VENDOR_CODE;
          `FWHC_OFF_HC_SET:       regRdata <= hcValue;
          `FWHC_OFF_HC_CLEAR:     regRdata <= hcValue;
          default:                regRdata <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/fwhc_params.svh
// Offsets, field positions, reset values and timing counts for the block.
`ifndef FWHC_PARAMS_SVH
`define FWHC_PARAMS_SVH

`define FWHC_OFF_PW_FAIL_HIGH  12'h03c
`define FWHC_OFF_VENDOR        12'h040
`define FWHC_OFF_HC_SET        12'h050
`define FWHC_OFF_HC_CLEAR      12'h054
`define FWHC_PHY_LO_FIRST      12'h0dc
`define FWHC_PHY_LO_LAST       12'h0f0
`define FWHC_PHY_HI_FIRST      12'h100
`define FWHC_PHY_HI_LAST       12'h11c

`define FWHC_BIT_IMAGE_OK      31
`define FWHC_BIT_SKIP_SWAP     30
`define FWHC_BIT_LATE_ACK      29
`define FWHC_BIT_PHY_OWNER     23
`define FWHC_BIT_PHY_ENH       22
`define FWHC_BIT_LINK_POWER    19
`define FWHC_BIT_POSTED_WR     18
`define FWHC_BIT_LINK_ACTIVE   17
`define FWHC_BIT_SW_RESTART    16

`define FWHC_RST_IMAGE_OK      1'b0
`define FWHC_RST_SKIP_SWAP     1'b0
`define FWHC_RST_LATE_ACK      1'b0
`define FWHC_RST_PHY_OWNER     1'b1
`define FWHC_RST_PHY_ENH       1'b0
`define FWHC_RST_LINK_POWER    1'b0
`define FWHC_RST_POSTED_WR     1'b0
`define FWHC_RST_LINK_ACTIVE   1'b0
`define FWHC_RST_CAPTURE       32'h0000_0000
`define FWHC_ALL_ONES          32'hffff_ffff

`define FWHC_RESTART_CYCLES    4'h8

`endif

// File: verilog/fwhc_pkg.sv
// Types shared by the host control register block.
`default_nettype none
package fwhc_pkg;
  typedef logic [31:0] fwhc_word_t;
  typedef logic [11:0] fwhc_addr_t;
  typedef enum logic [0:0] {
    FWHC_RS_IDLE,
    FWHC_RS_FLUSH
  } fwhc_restart_t;
endpackage
`default_nettype wire

// File: verilog/fwhc_sync.sv
// Two-stage synchroniser for a level arriving from another clock domain.
`default_nettype none
module fwhc_sync (
  input  wire logic clk,     // Block clock.
  input  wire logic rstn,    // Asynchronous reset, active low.
  input  wire logic async,   // Level from the foreign domain.
  output var  logic synced   // Level safe to read in this domain.
);
  logic stage1;

  // Only the second stage reads the first, to contain metastability.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      synced <= 1'b0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule
`default_nettype wire
